// File: design/scs_pkg.sv
// Constants shared by the slave clock-stretch logic.
// Assumes a single system clock domain; nothing here is clocked.
package scs_pkg;

    // =========================================================
    // Falling-edge counting within a byte.
    // =========================================================
    // Count after a start: the start's own SCL fall brings it to zero.
    localparam logic [3:0] SCS_COUNT_START = 4'hF;
    localparam logic [3:0] SCS_COUNT_RESET = 4'hF;
    localparam logic [3:0] SCS_COUNT_ZERO = 4'h0;
    localparam logic [3:0] SCS_COUNT_FIRST = 4'h1;
    // Fall that ends the eighth bit, and fall that ends the acknowledge.
    localparam logic [3:0] SCS_FALL_BYTE_END = 4'h8;
    localparam logic [3:0] SCS_FALL_ACK_END = 4'h9;

    // =========================================================
    // Values after reset.
    // =========================================================
    localparam logic SCS_RELEASE_RESET = 1'b1;
    localparam logic SCS_UA_HOLD_RESET = 1'b0;
    localparam logic SCS_OE_RESET = 1'b0;
    localparam logic SCS_SCL_PIN_RESET = 1'b1;

endpackage : scs_pkg

// File: design/scs_scl_sync.sv
// Two-stage synchroniser for the SCL pin with a falling-edge pulse.
// Assumes the pin is asynchronous to sys_clk_in and slower by far.
`timescale 1ns/10ps

module scs_scl_sync (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic scl_pin_in,
    output logic scl_level_out,
    output logic scl_fall_out
);

    logic stage_one;
    logic stage_two;
    logic stage_prev;
    logic next_stage_one;
    logic next_stage_two;
    logic next_stage_prev;

    // =========================================================
    // Synchroniser and edge finder.
    // =========================================================
    // The first stage feeds only the second; the edge finder looks at the later stages.
    always_comb begin
        next_stage_one = scl_pin_in;
        next_stage_two = stage_one;
        next_stage_prev = stage_two;
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage_one <= scs_pkg::SCS_SCL_PIN_RESET;
            stage_two <= scs_pkg::SCS_SCL_PIN_RESET;
            stage_prev <= scs_pkg::SCS_SCL_PIN_RESET;
        end else begin
            stage_one <= next_stage_one;
            stage_two <= next_stage_two;
            stage_prev <= next_stage_prev;
        end
    end

    assign scl_level_out = stage_two;
    assign scl_fall_out = stage_prev & ~stage_two;

endmodule : scs_scl_sync

// File: design/scs_clock_stretch.sv
// Clock-stretch control for the slave side of a two-wire serial port.
// Assumes a byte engine on sys_clk_in that reports start as a pulse, and byte kind, match, direction
// and acknowledge as levels, and a pad that turns scl_oe_out into an open-drain pull.
`timescale 1ns/10ps

module scs_clock_stretch (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic scl_pin_in,
    input wire logic port_enable_in,
    input wire logic start_seen_in,
    input wire logic byte_is_address_in,
    input wire logic address_match_in,
    input wire logic read_request_in,
    input wire logic ack_seen_in,
    input wire logic ten_bit_mode_in,
    input wire logic update_address_flag_in,
    input wire logic stretch_enable_in,
    input wire logic address_hold_enable_in,
    input wire logic data_hold_enable_in,
    input wire logic release_set_in,
    input wire logic release_clear_in,
    input wire logic address_write_in,
    output logic scl_out,
    output logic scl_oe_out,
    output logic scl_release_bit_out,
    output logic address_hold_active_out,
    output logic [3:0] fall_count_out
);

    logic scl_level;
    logic scl_fall;
    logic [3:0] fall_count;
    logic release_bit;
    logic ua_hold;
    logic scl_oe;
    logic scl_drive;
    logic [3:0] next_fall_count;
    logic next_release_bit;
    logic next_ua_hold;
    logic next_scl_oe;
    logic eighth_fall;
    logic ninth_fall;
    logic hw_clear;
    logic ua_set;
    logic hold_req;

    // =========================================================
    // Pin sampling.
    // =========================================================
    scs_scl_sync u_scl_sync (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .scl_pin_in(scl_pin_in),
        .scl_level_out(scl_level),
        .scl_fall_out(scl_fall)
    );

    // =========================================================
    // Falling-edge counter.
    // =========================================================
    // A start loads a value whose next fall lands on zero, so bit falls count one to eight.
    always_comb begin
        next_fall_count = fall_count;
        if (!port_enable_in || start_seen_in) begin
            next_fall_count = scs_pkg::SCS_COUNT_START;
        end else if (scl_fall) begin
            if (fall_count == scs_pkg::SCS_COUNT_START) begin
                next_fall_count = scs_pkg::SCS_COUNT_ZERO;
            end else if (fall_count == scs_pkg::SCS_FALL_ACK_END) begin
                next_fall_count = scs_pkg::SCS_COUNT_FIRST;
            end else begin
                next_fall_count = 4'(fall_count + scs_pkg::SCS_COUNT_FIRST);
            end
        end
    end

    assign eighth_fall = scl_fall && (next_fall_count == scs_pkg::SCS_FALL_BYTE_END);
    assign ninth_fall = scl_fall && (next_fall_count == scs_pkg::SCS_FALL_ACK_END);

    // =========================================================
    // Hardware hold decisions.
    // =========================================================
    // The buffer-full flag is deliberately absent here, so an early read cannot cancel a hold.
    always_comb begin
        hw_clear = 1'b0;
        ua_set = 1'b0;
        if (eighth_fall) begin
            if (byte_is_address_in && address_match_in && address_hold_enable_in) begin
                hw_clear = 1'b1;
            end
            if (!byte_is_address_in && !read_request_in && data_hold_enable_in) begin
                hw_clear = 1'b1;
            end
        end
        if (ninth_fall) begin
            if (byte_is_address_in && ack_seen_in && read_request_in) begin
                hw_clear = 1'b1;
            end
            if (stretch_enable_in && ack_seen_in) begin
                hw_clear = 1'b1;
            end
            if (byte_is_address_in && ten_bit_mode_in && update_address_flag_in) begin
                ua_set = 1'b1;
            end
        end
    end

    // =========================================================
    // Release bit, update-address hold and SCL drive.
    // =========================================================
    assign hold_req = !release_bit || ua_hold;

    always_comb begin
        next_release_bit = release_bit;
        next_ua_hold = ua_hold;
        next_scl_oe = scl_oe;
        if (!port_enable_in) begin
            next_release_bit = scs_pkg::SCS_RELEASE_RESET;
            next_ua_hold = scs_pkg::SCS_UA_HOLD_RESET;
            next_scl_oe = scs_pkg::SCS_OE_RESET;
        end else begin
            // A hardware clear beats a software write in the same cycle, so no hold is missed.
            if (hw_clear) begin
                next_release_bit = 1'b0;
            end else if (release_set_in) begin
                next_release_bit = 1'b1;
            end else if (release_clear_in) begin
                next_release_bit = 1'b0;
            end
            if (ua_set) begin
                next_ua_hold = 1'b1;
            end else if (address_write_in) begin
                next_ua_hold = 1'b0;
            end
            if (!hold_req) begin
                next_scl_oe = 1'b0;
            end else if (!scl_level) begin
                next_scl_oe = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fall_count <= scs_pkg::SCS_COUNT_RESET;
            release_bit <= scs_pkg::SCS_RELEASE_RESET;
            ua_hold <= scs_pkg::SCS_UA_HOLD_RESET;
            scl_oe <= scs_pkg::SCS_OE_RESET;
            scl_drive <= 1'b0;
        end else begin
            fall_count <= next_fall_count;
            release_bit <= next_release_bit;
            ua_hold <= next_ua_hold;
            scl_oe <= next_scl_oe;
            scl_drive <= 1'b0;
        end
    end

    // Once we let go, the wire stays low until the master and others let go too.
    assign scl_out = scl_drive;
    assign scl_oe_out = scl_oe;
    assign scl_release_bit_out = release_bit;
    assign address_hold_active_out = ua_hold;
    assign fall_count_out = fall_count;

    // =========================================================
    // Checks.
    // =========================================================
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence s_hold_wanted_low;
        port_enable_in && hold_req && !scl_level;
    endsequence

    sequence s_hold_still_wanted;
        port_enable_in && hold_req;
    endsequence

    sequence s_ack_end_read;
        port_enable_in && ninth_fall && byte_is_address_in && ack_seen_in && read_request_in;
    endsequence

    a_hold_grabs_low: assert property (s_hold_wanted_low ##1 s_hold_still_wanted |-> scl_oe)
        else $error("SCL not held after it was sampled low");
    a_never_pull_high: assert property ($rose(scl_oe) |-> $past(!scl_level))
        else $error("SCL pulled while it was still high");
    a_no_hold_released: assert property (port_enable_in && release_bit && !ua_hold |=> !scl_oe)
        else $error("SCL still held after release");
    a_sw_release_set: assert property (port_enable_in && release_set_in && !hw_clear |=> release_bit)
        else $error("Release bit not set by software");
    a_read_clears: assert property (s_ack_end_read |=> !release_bit ##1 (scl_oe || scl_level))
        else $error("Release bit not cleared after read address");
    a_sen_clears: assert property (port_enable_in && ninth_fall && stretch_enable_in && ack_seen_in
        |=> !release_bit)
        else $error("No stretch after acknowledge with stretch enabled");
    a_ua_hold_set: assert property (port_enable_in && ninth_fall && byte_is_address_in && ten_bit_mode_in
        && update_address_flag_in |=> ua_hold && (release_bit == $past(release_bit) || $past(hw_clear)
        || $past(release_set_in) || $past(release_clear_in)))
        else $error("Update-address hold missing or release bit touched");
    a_ua_release: assert property (port_enable_in && address_write_in && !ua_set |=> !ua_hold)
        else $error("Update-address hold not ended by address write");
    a_addr_hold: assert property (port_enable_in && eighth_fall && byte_is_address_in && address_match_in
        && address_hold_enable_in |=> !release_bit)
        else $error("Address hold did not clear release bit");
    a_data_hold: assert property (port_enable_in && eighth_fall && !byte_is_address_in && !read_request_in
        && data_hold_enable_in |=> !release_bit)
        else $error("Data hold did not clear release bit");
    a_disable_drops: assert property (!port_enable_in |=> !scl_oe && release_bit && !ua_hold)
        else $error("Hold survives port disable");

endmodule : scs_clock_stretch

// File: test/scs_master_model.sv
// Behavioural bus master that clocks SCL as an open-drain wire with a pull-up.
// Assumes the device pad pulls SCL low while scl_oe_in is high.
`timescale 1ns/10ps

module scs_master_model (
    input wire logic scl_oe_in,
    input wire logic go_in,
    input wire logic [3:0] n_falls_in,
    output logic scl_wire_out,
    output logic [3:0] falls_out
);
    logic master_low;
    int w;
    // Pull-up: the wire is high unless some party pulls it low.
    assign scl_wire_out = !(master_low || scl_oe_in);
    initial begin
        master_low = 1'b0;
        falls_out = 4'h0;
        forever begin
            @(posedge go_in);
            falls_out = 4'h0;
            // Keep every master change off the system clock edges, so the synchroniser never races it.
            #5;
            while (falls_out != n_falls_in) begin
                #40 master_low = 1'b1;
                falls_out = falls_out + 4'h1;
                #120 master_low = 1'b0;
                // The clock pauses while a slave keeps the line low.
                w = 0;
                while (!scl_wire_out && w < 400) begin
                    #10 w = w + 1;
                end
            end
        end
    end
endmodule : scs_master_model

// File: test/scs_clock_stretch_tb.sv
// Self-checking bench for the slave clock-stretch block.
// Assumes scs_master_model as the far side; engine status is driven as levels.
`timescale 1ns/10ps

module scs_clock_stretch_tb;
    logic clk = 1'b0, rst_n = 1'b0, port_en = 1'b1, start = 1'b0, is_addr = 1'b0, match = 1'b0;
    logic rd = 1'b0, ack = 1'b0, ten = 1'b0, ua = 1'b0, stretch_enable = 1'b0, address_hold_enable = 1'b0, data_hold_enable = 1'b0;
    logic rset = 1'b0, rclr = 1'b0, awr = 1'b0, go = 1'b0;
    logic [3:0] n_falls = 4'h0;
    logic scl, scl_o, oe, rel, ua_act;
    logic [3:0] cnt, falls;
    int n_mismatch = 0, check_count = 0;
    initial begin
        forever #10 clk = ~clk;
    end
    scs_master_model i_scs_master_model (.scl_oe_in(oe), .go_in(go), .n_falls_in(n_falls),
        .scl_wire_out(scl), .falls_out(falls));
    scs_clock_stretch i_scs_clock_stretch (.sys_clk_in(clk), .reset_n_in(rst_n), .scl_pin_in(scl),
        .port_enable_in(port_en), .start_seen_in(start), .byte_is_address_in(is_addr),
        .address_match_in(match), .read_request_in(rd), .ack_seen_in(ack), .ten_bit_mode_in(ten),
        .update_address_flag_in(ua), .stretch_enable_in(stretch_enable), .address_hold_enable_in(address_hold_enable),
        .data_hold_enable_in(data_hold_enable), .release_set_in(rset), .release_clear_in(rclr),
        .address_write_in(awr), .scl_out(scl_o), .scl_oe_out(oe), .scl_release_bit_out(rel),
        .address_hold_active_out(ua_act), .fall_count_out(cnt));

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic bad(input string what);
        n_mismatch++;
        $display("FAIL %0t timeout %s", $time, what);
        final_report();
    endtask : bad

    // Start pulse, then n falls from the master; status levels stand throughout.
    task automatic frame(input logic a, m, r, k, input logic [3:0] n);
        int i;
        @(posedge clk);
        is_addr <= a;
        match <= m;
        rd <= r;
        ack <= k;
        n_falls <= n;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (i = 0; i < 500 && falls != n; i++) @(posedge clk);
        if (falls != n) bad("falls");
        repeat (10) @(posedge clk);
    endtask : frame

    task automatic wait_high();
        int i;
        for (i = 0; i < 100 && scl !== 1'b1; i++) @(posedge clk);
        if (scl !== 1'b1) bad("scl high");
        @(posedge clk);
    endtask : wait_high

    task automatic release_sw();
        @(posedge clk);
        rset <= 1'b1;
        @(posedge clk);
        rset <= 1'b0;
        wait_high();
        check({2'b00, rel, oe}, 4'h2, "after release");
    endtask : release_sw

    task automatic t_reset();
        check({scl_o, oe, rel, ua_act}, 4'h2, "reset outputs");
        check(cnt, scs_pkg::SCS_COUNT_RESET, "reset count");
        $display("test reset done");
    endtask : t_reset

    task automatic t_read();
        frame(1'b1, 1'b1, 1'b1, 1'b1, 4'hA);
        check({scl_o, scl, rel, oe}, 4'h1, "read hold");
        check(cnt, scs_pkg::SCS_FALL_ACK_END, "ack fall count");
        release_sw();
        $display("test read done");
    endtask : t_read

    task automatic t_stretch();
        stretch_enable <= 1'b1;
        frame(1'b0, 1'b0, 1'b0, 1'b1, 4'hA);
        check({scl, rel, oe}, 4'h1, "stretch hold");
        release_sw();
        stretch_enable <= 1'b0;
        $display("test stretch done");
    endtask : t_stretch

    task automatic t_byte_holds();
        address_hold_enable <= 1'b1;
        frame(1'b1, 1'b0, 1'b0, 1'b0, 4'h9);
        check({scl, rel, oe}, 4'h6, "no hold without match");
        frame(1'b1, 1'b1, 1'b0, 1'b0, 4'h9);
        check({scl, rel, oe}, 4'h1, "address hold");
        check(cnt, scs_pkg::SCS_FALL_BYTE_END, "byte fall count");
        release_sw();
        address_hold_enable <= 1'b0;
        data_hold_enable <= 1'b1;
        frame(1'b0, 1'b0, 1'b0, 1'b0, 4'h9);
        check({scl, rel, oe}, 4'h1, "data hold");
        release_sw();
        data_hold_enable <= 1'b0;
        $display("test byte holds done");
    endtask : t_byte_holds

    task automatic t_ten_bit();
        ten <= 1'b1;
        ua <= 1'b1;
        frame(1'b1, 1'b0, 1'b0, 1'b1, 4'hA);
        check({scl, rel, oe, ua_act}, 4'h7, "update hold");
        ua <= 1'b0;
        awr <= 1'b1;
        @(posedge clk);
        awr <= 1'b0;
        wait_high();
        check({rel, oe, ua_act}, 4'h4, "address write");
        ten <= 1'b0;
        $display("test ten bit done");
    endtask : t_ten_bit

    task automatic t_idle_clear();
        rclr <= 1'b1;
        @(posedge clk);
        rclr <= 1'b0;
        repeat (10) @(posedge clk);
        check({rel, oe}, 4'h0, "no pull while high");
        frame(1'b0, 1'b0, 1'b0, 1'b0, 4'h1);
        check({scl, oe}, 4'h1, "hold after low");
        check(cnt, scs_pkg::SCS_COUNT_ZERO, "start fall count");
        port_en <= 1'b0;
        wait_high();
        check(oe, 4'h0, "disable drops hold");
        port_en <= 1'b1;
        rclr <= 1'b1;
        @(posedge clk);
        rclr <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check({oe, rel}, 4'h1, "second reset");
        $display("test idle clear done");
    endtask : t_idle_clear

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_read();
        t_stretch();
        t_byte_holds();
        t_ten_bit();
        t_idle_clear();
        final_report();
    end
endmodule : scs_clock_stretch_tb
